// *** hdl/pm_regs_pkg.sv ***
// Purpose: Constants for the power-management control and status register set.
// Assumes: Byte-addressed configuration space with a 32-bit dword at 0xa4.
// Notes: Offsets are byte addresses within configuration space.
package pm_regs_pkg;
    localparam logic [7:0] ctl_status_offset = 8'ha4;
    localparam logic [7:0] bridge_ext_offset = 8'ha6;
    localparam logic [7:0] power_data_offset = 8'ha7;
    localparam logic [5:0] dword_index = 6'h29;
    localparam int wake_status_bit = 15;
    localparam int wake_enable_bit = 8;
    localparam logic [1:0] state_d0 = 2'h0;
    localparam logic [1:0] state_d3hot = 2'h3;
    localparam logic [1:0] state_reset = 2'h0;
    localparam logic [7:0] bridge_ext_value = 8'hc0;
    localparam logic [7:0] power_data_value = 8'h00;
endpackage : pm_regs_pkg

// *** hdl/pm_control_status_regs.sv ***
// Purpose: Power-management control/status, bridge extension and data registers.
// Assumes: Configuration accesses arrive as one-cycle strobes with a dword index
//          and byte enables; reads answer on the next clock.
// Notes: Writes to read-only fields are accepted and discarded.
//
// Operation
// - Wake status sets on every wake event, whatever the enable bit says.
// - Writing one clears wake status and drops wake; writing zero does nothing.
// - Wake output is driven only while the wake enable bit is one.
// - Power state field reads back and sets the state, 00 D0 to 11 D3hot.
// - Leaving D3hot for D0 raises an internal reset of the other register groups.
// - That internal reset spares this register set and other excluded registers.
// - Data scale reads 00b and data select reads 0h always.
// - Bits 7 to 2 of control/status read zero and ignore writes.
// - Bus power/clock control enable bit reads one always.
// - Without bus power/clock control, power state does not steer secondary bus.
// - D3hot action bit chooses power removal (0) or clock stop (1).
// - Bits 5 to 0 of the bridge extension read zero.
// - Power data register always reads 00h.
`timescale 1ns/1ps
`default_nettype none
module pm_control_status_regs (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [5:0] cfg_index,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic wake_event,
    output logic [31:0] cfg_rdata,
    output logic cfg_rvalid,
    output logic wake_n,
    output logic internal_reset,
    output logic [1:0] power_state,
    output logic sec_clock_stop,
    output logic sec_power_off
);
    typedef struct packed {
        logic wake_status_r;
        logic wake_enable_r;
        logic [1:0] power_state_r;
        logic [31:0] rdata_r;
        logic rvalid_r;
        logic wake_n_r;
        logic int_reset_r;
        logic clock_stop_r;
        logic power_off_r;
    } state_type;

    state_type cur_r;
    state_type cur_nxt;
    logic hit;
    logic bus_power_clock_ctl_enable;
    logic d3_action;

    ////////////////////////////////////////////////////////////////////////////
    // fixed policy bits
    assign bus_power_clock_ctl_enable = pm_regs_pkg::bridge_ext_value[7];
    assign d3_action = pm_regs_pkg::bridge_ext_value[6];
    assign hit = (cfg_index == pm_regs_pkg::dword_index);

    // The fixed register values must match the policy that this logic builds in.
    if (pm_regs_pkg::bridge_ext_value[5:0] != 6'h00) begin : g_ext_check
        $error("bridge extension reserved bits must be zero");
    end
    if (pm_regs_pkg::power_data_value != 8'h00) begin : g_data_check
        $error("power data register must read zero");
    end

    // The event is applied after the write, so a wake that lands in the same cycle
    // as a clear is never lost; software sees it on its next read.
    always_comb begin
        cur_nxt = cur_r;
        cur_nxt.int_reset_r = 1'b0;
        cur_nxt.rvalid_r = cfg_rd;
        cur_nxt.rdata_r = 32'h0000_0000;
        if (cfg_rd && hit) begin
            cur_nxt.rdata_r[15:0] = {cur_r.wake_status_r, 6'h00, cur_r.wake_enable_r,
                                     6'h00, cur_r.power_state_r};
            cur_nxt.rdata_r[23:16] = pm_regs_pkg::bridge_ext_value;
            cur_nxt.rdata_r[31:24] = pm_regs_pkg::power_data_value;
        end
        if (cfg_wr && hit && cfg_be[1]) begin
            cur_nxt.wake_enable_r = cfg_wdata[pm_regs_pkg::wake_enable_bit];
            if (cfg_wdata[pm_regs_pkg::wake_status_bit]) begin
                cur_nxt.wake_status_r = 1'b0;
            end
        end
        if (wake_event) begin
            cur_nxt.wake_status_r = 1'b1;
        end
        if (cfg_wr && hit && cfg_be[0]) begin
            cur_nxt.power_state_r = cfg_wdata[1:0];
            if (cur_r.power_state_r == pm_regs_pkg::state_d3hot &&
                cfg_wdata[1:0] == pm_regs_pkg::state_d0) begin
                cur_nxt.int_reset_r = 1'b1;
            end
        end
        cur_nxt.wake_n_r = ~(cur_nxt.wake_status_r & cur_nxt.wake_enable_r);
        cur_nxt.clock_stop_r = bus_power_clock_ctl_enable && d3_action &&
                               cur_nxt.power_state_r == pm_regs_pkg::state_d3hot;
        cur_nxt.power_off_r = bus_power_clock_ctl_enable && !d3_action &&
                              cur_nxt.power_state_r == pm_regs_pkg::state_d3hot;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cur_r <= '{wake_status_r: 1'b0, wake_enable_r: 1'b0,
                       power_state_r: pm_regs_pkg::state_reset, rdata_r: 32'h0000_0000,
                       rvalid_r: 1'b0, wake_n_r: 1'b1, int_reset_r: 1'b0,
                       clock_stop_r: 1'b0, power_off_r: 1'b0};
        end else begin
            cur_r <= cur_nxt;
        end
    end

    assign cfg_rdata = cur_r.rdata_r;
    assign cfg_rvalid = cur_r.rvalid_r;
    assign wake_n = cur_r.wake_n_r;
    assign internal_reset = cur_r.int_reset_r;
    assign power_state = cur_r.power_state_r;
    assign sec_clock_stop = cur_r.clock_stop_r;
    assign sec_power_off = cur_r.power_off_r;

    ////////////////////////////////////////////////////////////////////////////
    // status follows event
    a_status_sets: assert property (@(posedge clk) disable iff (sys_rst)
        wake_event |=> cur_r.wake_status_r) else $error("wake status missed event");
    a_clear_by_one: assert property (@(posedge clk) disable iff (sys_rst)
        (cfg_wr && hit && cfg_be[1] && cfg_wdata[15] && !wake_event) |=> !cur_r.wake_status_r)
        else $error("wake status not cleared");
    a_zero_keeps: assert property (@(posedge clk) disable iff (sys_rst)
        (cur_r.wake_status_r && !(cfg_wr && hit && cfg_be[1] && cfg_wdata[15]))
        |=> cur_r.wake_status_r) else $error("wake status lost");
    a_wake_gated: assert property (@(posedge clk) disable iff (sys_rst)
        !wake_n |-> (cur_r.wake_enable_r && cur_r.wake_status_r))
        else $error("wake driven without enable");
    a_state_write: assert property (@(posedge clk) disable iff (sys_rst)
        (cfg_wr && hit && cfg_be[0]) |=> power_state == $past(cfg_wdata[1:0]))
        else $error("power state not taken");
    a_d3_reset: assert property (@(posedge clk) disable iff (sys_rst)
        internal_reset |-> ($past(power_state) == 2'h3 && power_state == 2'h0)
        ##1 !internal_reset) else $error("bad internal reset");
    a_read_const: assert property (@(posedge clk) disable iff (sys_rst)
        cfg_rvalid |-> (cfg_rdata[14:2] == 13'h0000 || cfg_rdata[14:2] == 13'h0040) &&
        cfg_rdata[31:16] == 16'h00c0 || cfg_rdata == 32'h0000_0000)
        else $error("constant field wrong");
    a_bus_ctl: assert property (@(posedge clk) disable iff (sys_rst)
        sec_clock_stop |-> power_state == 2'h3 && !sec_power_off)
        else $error("secondary bus control wrong");
    a_set_wins: assert property (@(posedge clk) disable iff (sys_rst)
        (wake_event && cfg_wr && hit && cfg_be[1] && cfg_wdata[15]) |=> cur_r.wake_status_r)
        else $error("wake event lost to clear");
    a_wake_drops: assert property (@(posedge clk) disable iff (sys_rst)
        (cfg_wr && hit && cfg_be[1] && cfg_wdata[15] && !wake_event) |=> wake_n)
        else $error("wake held after clear");
    a_enable_off: assert property (@(posedge clk) disable iff (sys_rst)
        (cfg_wr && hit && cfg_be[1] && !cfg_wdata[8]) |=> wake_n)
        else $error("wake held without enable");
    a_state_hold: assert property (@(posedge clk) disable iff (sys_rst)
        !(cfg_wr && hit && cfg_be[0]) |=> $stable(power_state))
        else $error("power state changed unwritten");
    a_reset_cause: assert property (@(posedge clk) disable iff (sys_rst)
        (cfg_wr && hit && cfg_be[0] && power_state == 2'h3 && cfg_wdata[1:0] == 2'h0)
        |=> internal_reset) else $error("internal reset missing");
    a_regs_kept: assert property (@(posedge clk) disable iff (sys_rst)
        (internal_reset && !cfg_wr) |=> $stable(cur_r.wake_enable_r))
        else $error("enable lost on internal reset");
    a_reserved_zero: assert property (@(posedge clk) disable iff (sys_rst)
        (cfg_rd && hit) |=> cfg_rdata[7:2] == 6'h00)
        else $error("reserved bits not zero");
    a_ext_fixed: assert property (@(posedge clk) disable iff (sys_rst)
        (cfg_rd && hit) |=> cfg_rdata[31:16] == 16'h00c0)
        else $error("extension or data byte wrong");
    a_clock_stop: assert property (@(posedge clk) disable iff (sys_rst)
        (power_state == 2'h3) |-> (sec_clock_stop && !sec_power_off))
        else $error("clock stop missing in D3hot");
    a_power_kept: assert property (@(posedge clk) disable iff (sys_rst)
        !sec_power_off)
        else $error("secondary power removed");
    a_unmapped_zero: assert property (@(posedge clk) disable iff (sys_rst)
        (cfg_rd && !hit) |=> cfg_rdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_rvalid_pulse: assert property (@(posedge clk) disable iff (sys_rst)
        cfg_rd |=> cfg_rvalid)
        else $error("read answer missing");
endmodule : pm_control_status_regs
`default_nettype wire

// *** bench/pm_control_status_regs_bench.sv ***
// Purpose: Self-checking bench for the power-management register set.
// Assumes: Inputs change on the falling edge; reads answer one cycle later.
// Notes: Table rows hold plain writes; wake, D3hot exit and resets are by hand.
`timescale 1ns/1ps
`default_nettype none
module pm_control_status_regs_bench;
    logic clk = 1'b0, sys_rst = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0, wake_event = 1'b0;
    logic [5:0] cfg_index = pm_regs_pkg::dword_index;
    logic [3:0] cfg_be = 4'h0;
    logic [31:0] cfg_wdata = 32'h0, cfg_rdata;
    logic cfg_rvalid, wake_n, internal_reset, sec_clock_stop, sec_power_off;
    logic [1:0] power_state;
    int n_mismatch = 0, comparisons = 0;
    typedef struct {logic [3:0] be; logic [31:0] wd; logic [31:0] rd;} row_type;
    row_type rows [5] = '{'{4'hf, 32'hffff_ffff, 32'h00c0_0103},
        '{4'h1, 32'h0000_0002, 32'h00c0_0102}, '{4'h2, 32'h0000_0000, 32'h00c0_0002},
        '{4'h1, 32'h0000_0001, 32'h00c0_0001}, '{4'h1, 32'h0000_0000, 32'h00c0_0000}};
    pm_control_status_regs i_dut (.clk(clk), .sys_rst(sys_rst), .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd), .cfg_index(cfg_index), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .wake_event(wake_event), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
        .wake_n(wake_n), .internal_reset(internal_reset), .power_state(power_state),
        .sec_clock_stop(sec_clock_stop), .sec_power_off(sec_power_off));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [3:0] be, input logic [31:0] d);
        cfg_be = be;
        cfg_wdata = d;
        cfg_wr = 1'b1;
        @(posedge clk);
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask : wr
    // The strobe is dropped at the falling edge, so back-to-back calls never collide.
    task automatic rdchk(input string what, input logic [31:0] exp);
        cfg_rd = 1'b1;
        @(posedge clk);
        @(negedge clk);
        cfg_rd = 1'b0;
        chk("rvalid", 32'h1, {31'h0, cfg_rvalid});
        chk(what, exp, cfg_rdata);
    endtask : rdchk
    task automatic test_done();
        $display("Counts: %0d mismatches in %0d comparisons", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #50 clk = ~clk;
    end
    // The run needs about forty cycles; some thirty times that means a hang.
    initial begin
        #120000;
        n_mismatch++;
        test_done();
    end
    initial begin
        repeat (4) @(negedge clk);
        sys_rst = 1'b0;
        rdchk("reset dword", 32'h00c0_0000);
        for (int i = 0; i < 5; i++) begin
            wr(rows[i].be, rows[i].wd);
            rdchk("table row", rows[i].rd);
        end
        $display("Table rows done");
        wake_event = 1'b1;
        @(negedge clk);
        wake_event = 1'b0;
        rdchk("status set", 32'h00c0_8000);
        chk("wake_n disabled", 32'h1, {31'h0, wake_n});
        wr(4'h2, 32'h0000_0100);
        @(negedge clk);
        wr(4'h2, 32'h0000_0100);
        chk("wake_n enabled", 32'h0, {31'h0, wake_n});
        rdchk("zero write keeps", 32'h00c0_8100);
        wake_event = 1'b1;
        wr(4'h2, 32'h0000_8100);
        wake_event = 1'b0;
        rdchk("set beats clear", 32'h00c0_8100);
        wr(4'h2, 32'h0000_0000);
        chk("wake_n enable off", 32'h1, {31'h0, wake_n});
        @(negedge clk);
        wr(4'h2, 32'h0000_8100);
        rdchk("status cleared", 32'h00c0_0100);
        chk("wake_n cleared", 32'h1, {31'h0, wake_n});
        $display("Wake tests done");
        wr(4'h1, 32'h0000_0003);
        @(negedge clk);
        chk("state port", 32'h3, {30'h0, power_state});
        chk("clock stop", 32'h1, {31'h0, sec_clock_stop});
        chk("power off", 32'h0, {31'h0, sec_power_off});
        wr(4'h1, 32'h0000_0000);
        chk("internal reset", 32'h1, {31'h0, internal_reset});
        rdchk("kept after exit", 32'h00c0_0100);
        wr(4'h1, 32'h0000_0002);
        @(negedge clk);
        wr(4'h1, 32'h0000_0000);
        chk("no reset from D2", 32'h0, {31'h0, internal_reset});
        chk("clock stop off", 32'h0, {31'h0, sec_clock_stop});
        $display("D3hot exit done");
        cfg_index = 6'h2a;
        @(negedge clk);
        wr(4'hf, 32'hffff_ffff);
        rdchk("unmapped", 32'h0);
        cfg_index = pm_regs_pkg::dword_index;
        @(negedge clk);
        rdchk("mapped intact", 32'h00c0_0100);
        wr(4'h1, 32'h0000_0003);
        sys_rst = 1'b1;
        @(negedge clk);
        chk("state in reset", 32'h0, {30'h0, power_state});
        chk("clock stop in reset", 32'h0, {31'h0, sec_clock_stop});
        chk("wake_n in reset", 32'h1, {31'h0, wake_n});
        sys_rst = 1'b0;
        rdchk("second reset", 32'h00c0_0000);
        $display("Reset tests done");
        test_done();
    end
endmodule : pm_control_status_regs_bench
`default_nettype wire
